// ===== ccp_pkg.sv
`default_nettype none
package ccp_pkg;
	// ==========================================================
	// command word layouts
	localparam logic [3:0]  CFG_TAG_HI      = 4'h_C;
	localparam logic [2:0]  CFG_TAG_LO      = 3'h_2;
	localparam int          CFG_TAG_HI_MSB  = 15;
	localparam int          CFG_TAG_HI_LSB  = 12;
	localparam int          CFG_TAG_LO_MSB  = 11;
	localparam int          CFG_TAG_LO_LSB  = 9;
	localparam int          CFG_WIDTH_BIT   = 8;
	localparam int          CFG_LAW_BIT     = 7;
	localparam int          CFG_MASTER_BIT  = 6;
	localparam int          CFG_LONG_BIT    = 5;
	localparam int          CFG_OUT_MSB     = 4;
	localparam int          CFG_OUT_LSB     = 3;
	localparam int          CFG_SWAP_BIT    = 2;
	localparam int          CFG_RATE_BIT    = 1;
	localparam int          CFG_ZERO_BIT    = 0;
	localparam int          DIV_WIDE_BIT    = 15;
	localparam int          DIV_FRAME_MSB   = 14;
	localparam int          DIV_FRAME_LSB   = 5;
	localparam int          DIV_BCLK_MSB    = 4;
	localparam int          DIV_BCLK_LSB    = 0;
	localparam logic [3:0]  REC_TAG_HI      = 4'h_1;
	localparam logic [1:0]  REC_TAG_LO      = 2'h_3;
	localparam int          REC_TAG_LO_MSB  = 11;
	localparam int          REC_TAG_LO_LSB  = 10;
	localparam int          REC_FMT_MSB     = 9;
	localparam int          REC_FMT_LSB     = 7;
	localparam int          REC_ZERO_MSB    = 6;
	localparam int          REC_ZERO_LSB    = 2;
	localparam int          REC_TFR_MSB     = 1;
	localparam int          REC_TFR_LSB     = 0;
	// ==========================================================
	// field codes
	localparam logic [1:0]  ROUTE_DEFAULT   = 2'h_0;
	localparam logic [1:0]  ROUTE_C1        = 2'h_1;
	localparam logic [1:0]  ROUTE_C0        = 2'h_2;
	localparam logic [1:0]  ROUTE_BOTH      = 2'h_3;
	localparam logic [1:0]  TFR_REGS        = 2'h_0;
	localparam logic [1:0]  TFR_PORT        = 2'h_3;
	localparam logic [4:0]  BCLK_DIV_MIN    = 5'h_05;
	localparam logic [9:0]  FRAME_DIV_MIN   = 10'h_012;
	localparam logic [4:0]  SYNC_LEN_8      = 5'h_08;
	localparam logic [4:0]  SYNC_LEN_16     = 5'h_10;
	localparam logic [4:0]  SYNC_LEN_1      = 5'h_01;
	localparam logic [15:0] WORD_ZERO       = 16'h_0000;
	// ==========================================================
	// command parser states, gray coded
	typedef enum logic [1:0] {
		CCP_IDLE = 2'b00,
		CCP_DIV  = 2'b01,
		CCP_RESP = 2'b11
	} ccp_state_t;
endpackage : ccp_pkg
`default_nettype wire

// ===== ccp_divider.sv
`default_nettype none
// free-running divider: one-cycle tick every (div+1) enabled steps
module ccp_divider #(
	parameter int W = 5
) (
	// clock and reset
	input  wire logic         clk_sys_in,
	input  wire logic         rst_b_in,
	// control
	input  wire logic         run_in,
	input  wire logic         step_in,
	input  wire logic [W-1:0] div_in,
	// result
	output logic              tick_out
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         tick_d;
	logic         tick_q;

	// ==========================================================
	// a one-bit counter cannot hold any divide worth running
	if (W < 2) begin : g_width_check
		$error("ccp_divider: W must be at least 2");
	end

	// ==========================================================
	// count down, reload from divider field at zero
	always_comb begin
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (!run_in) begin
			cnt_d = div_in;
		end else if (step_in) begin
			if (cnt_q == '0) begin
				cnt_d  = div_in;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q - W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_out = tick_q;
endmodule : ccp_divider
`default_nettype wire

// ===== ccp_codec_port.sv
// Function
// - config word: tag, format bits, echoed back
// - set-rate bit makes next word dividers
// - width 0 companded 8-bit, 1 linear 16-bit
// - law 0 mu-law, 1 A-law
// - master drives clocks; slave after reset
// - long bit with divider wide bit selects long frame sync
// - routing bits steer playback output codecs
// - swap bit exchanges codec input streams
// - bit clock is main clock over field+1
// - frame sync is bit clock over field+1
// - sync one period, or 8/16 wide
// - record source and playback outputs selectable
// - record word layout checked and echoed
// - command when ready; reading clears response
// - transfer method 00 registers, 11 port
`default_nettype none
module ccp_codec_port (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_b_in,
	// command and response words
	input  wire logic        cmd_wr_in,
	input  wire logic [15:0] cmd_word_in,
	input  wire logic        resp_rd_in,
	output logic             cmd_ready_out,
	output logic             resp_ready_out,
	output logic [15:0]      resp_word_out,
	output logic             cmd_error_out,
	// decoded configuration
	output logic             linear16_out,
	output logic             alaw_out,
	output logic             master_out,
	output logic             long_sync_out,
	output logic [1:0]       play_route_out,
	output logic             in_swap_out,
	output logic [2:0]       recording_format_out,
	output logic             tfr_port_out,
	output logic             tfr_reserved_out,
	// codec data steering
	input  wire logic        rec_c0_in,
	input  wire logic        rec_c1_in,
	input  wire logic        play_in,
	output logic             rec_c0_out,
	output logic             rec_c1_out,
	output logic             play_c0_out,
	output logic             play_c1_out,
	// codec clocks (two-way pins)
	input  wire logic        bit_clock_in,
	input  wire logic        frame_sync_in,
	output logic             bit_clock_out,
	output logic             bit_clock_oe_out,
	output logic             frame_sync_out,
	output logic             frame_sync_oe_out,
	output logic             frame_start_out
);
	ccp_pkg::ccp_state_t state_q, state_d;
	logic [15:0] cfg_q, cfg_d, div_q, div_d, resp_q, resp_d, rec_q, rec_d;
	logic        rdy_q, rdy_d, err_q, err_d, width_set_q, width_set_d;
	logic        div_next_q, div_next_d, resp_rdy_q, resp_rdy_d;
	logic        tfr_port_q, tfr_port_d, tfr_rsv_q, tfr_rsv_d;
	logic        bclk_q, bclk_d, fs_q, fs_d, fs_prev_q, fstart_q, fstart_d;
	logic [4:0]  sync_cnt_q, sync_cnt_d;
	logic        half_tick, frame_tick, master, cfg_hit, rec_hit;
	assign master = cfg_q[ccp_pkg::CFG_MASTER_BIT];
	// ==========================================================
	// command word recognition
	assign cfg_hit = (cmd_word_in[ccp_pkg::CFG_TAG_HI_MSB:ccp_pkg::CFG_TAG_HI_LSB]
		== ccp_pkg::CFG_TAG_HI)
		&& (cmd_word_in[ccp_pkg::CFG_TAG_LO_MSB:ccp_pkg::CFG_TAG_LO_LSB]
		== ccp_pkg::CFG_TAG_LO)
		&& !cmd_word_in[ccp_pkg::CFG_ZERO_BIT];
	assign rec_hit = (cmd_word_in[ccp_pkg::CFG_TAG_HI_MSB:ccp_pkg::CFG_TAG_HI_LSB]
		== ccp_pkg::REC_TAG_HI)
		&& (cmd_word_in[ccp_pkg::REC_TAG_LO_MSB:ccp_pkg::REC_TAG_LO_LSB]
		== ccp_pkg::REC_TAG_LO)
		&& (cmd_word_in[ccp_pkg::REC_ZERO_MSB:ccp_pkg::REC_ZERO_LSB] == 5'h_00);

	// ==========================================================
	// command parser: every command taken while ready earns one response word
	always_comb begin
		state_d     = state_q;
		cfg_d       = cfg_q;
		div_d       = div_q;
		rec_d       = rec_q;
		resp_d      = resp_q;
		rdy_d       = rdy_q;
		err_d       = err_q;
		width_set_d = width_set_q;
		div_next_d  = div_next_q;
		case (state_q)
			ccp_pkg::CCP_IDLE, ccp_pkg::CCP_DIV: begin
				if (cmd_wr_in) begin
					rdy_d  = 1'b0;
					resp_d = cmd_word_in; // echo
					err_d  = 1'b0;
					if (state_q == ccp_pkg::CCP_DIV) begin
						div_d = cmd_word_in;
					end else if (cfg_hit) begin
						cfg_d = cmd_word_in;
						// width is frozen once set; a later change is flagged, kept old
						if (width_set_q && (cmd_word_in[ccp_pkg::CFG_WIDTH_BIT]
							!= cfg_q[ccp_pkg::CFG_WIDTH_BIT])) begin
							cfg_d[ccp_pkg::CFG_WIDTH_BIT] = cfg_q[ccp_pkg::CFG_WIDTH_BIT];
							err_d = 1'b1;
						end
						width_set_d = 1'b1;
					end else if (rec_hit) begin
						rec_d = cmd_word_in;
					end
					// set-rate arms the divider word, but only after this echo is read
					div_next_d = (state_q == ccp_pkg::CCP_IDLE) && cfg_hit
						&& cmd_word_in[ccp_pkg::CFG_RATE_BIT];
					state_d    = ccp_pkg::CCP_RESP;
				end
			end
			ccp_pkg::CCP_RESP: begin
				if (resp_rd_in) begin
					rdy_d   = 1'b1;
					state_d = div_next_q ? ccp_pkg::CCP_DIV : ccp_pkg::CCP_IDLE;
				end
			end
			default: state_d = ccp_pkg::CCP_IDLE;
		endcase
		// status flags taken from next values so the outputs come from flops
		resp_rdy_d = (state_d == ccp_pkg::CCP_RESP);
		tfr_port_d = (rec_d[ccp_pkg::REC_TFR_MSB:ccp_pkg::REC_TFR_LSB]
			== ccp_pkg::TFR_PORT);
		tfr_rsv_d  = !tfr_port_d && (rec_d[ccp_pkg::REC_TFR_MSB:ccp_pkg::REC_TFR_LSB]
			!= ccp_pkg::TFR_REGS);
	end

	// response is ready while waiting for the read
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			state_q     <= ccp_pkg::CCP_IDLE;
			cfg_q       <= ccp_pkg::WORD_ZERO; // slave after reset
			div_q       <= ccp_pkg::WORD_ZERO;
			rec_q       <= ccp_pkg::WORD_ZERO;
			resp_q      <= ccp_pkg::WORD_ZERO;
			rdy_q       <= 1'b1;
			err_q       <= 1'b0;
			width_set_q <= 1'b0;
			div_next_q  <= 1'b0;
			resp_rdy_q  <= 1'b0;
			tfr_port_q  <= 1'b0;
			tfr_rsv_q   <= 1'b0;
		end else begin
			state_q     <= state_d;
			cfg_q       <= cfg_d;
			div_q       <= div_d;
			rec_q       <= rec_d;
			resp_q      <= resp_d;
			rdy_q       <= rdy_d;
			err_q       <= err_d;
			width_set_q <= width_set_d;
			div_next_q  <= div_next_d;
			resp_rdy_q  <= resp_rdy_d;
			tfr_port_q  <= tfr_port_d;
			tfr_rsv_q   <= tfr_rsv_d;
		end
	end

	// ==========================================================
	// master clock generation: a tick every (field+1) main clocks gives one
	// bit clock pulse; the frame counter steps on those ticks
	ccp_divider #(.W(5)) u_bclk_div (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.run_in     (master),
		.step_in    (1'b1),
		.div_in     (div_q[ccp_pkg::DIV_BCLK_MSB:ccp_pkg::DIV_BCLK_LSB]),
		.tick_out   (half_tick)
	);
	ccp_divider #(.W(10)) u_frame_div (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.run_in     (master),
		.step_in    (half_tick),
		.div_in     (div_q[ccp_pkg::DIV_FRAME_MSB:ccp_pkg::DIV_FRAME_LSB]),
		.tick_out   (frame_tick)
	);

	// bit clock pulses once per divide period; frame counts bit clocks
	always_comb begin
		bclk_d     = master && half_tick;
		sync_cnt_d = sync_cnt_q;
		fs_d       = fs_q;
		fstart_d   = 1'b0;
		if (!master) begin
			// slave: align framing to the rising edge of incoming sync
			fs_d       = 1'b0;
			sync_cnt_d = 5'h_00;
			fstart_d   = frame_sync_in && !fs_prev_q;
		end else if (frame_tick) begin
			fstart_d = 1'b1;
			fs_d     = 1'b1;
			if (cfg_q[ccp_pkg::CFG_LONG_BIT] && div_q[ccp_pkg::DIV_WIDE_BIT]) begin
				sync_cnt_d = cfg_q[ccp_pkg::CFG_WIDTH_BIT]
					? ccp_pkg::SYNC_LEN_16 : ccp_pkg::SYNC_LEN_8;
			end else begin
				sync_cnt_d = ccp_pkg::SYNC_LEN_1;
			end
		end else if (bclk_q && fs_q) begin // whole bit clock periods
			sync_cnt_d = sync_cnt_q - 5'h_01;
			fs_d       = (sync_cnt_q > ccp_pkg::SYNC_LEN_1);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			bclk_q     <= 1'b0;
			fs_q       <= 1'b0;
			fs_prev_q  <= 1'b0;
			fstart_q   <= 1'b0;
			sync_cnt_q <= 5'h_00;
		end else begin
			bclk_q     <= bclk_d;
			fs_q       <= fs_d;
			fs_prev_q  <= frame_sync_in;
			fstart_q   <= fstart_d;
			sync_cnt_q <= sync_cnt_d;
		end
	end

	// ==========================================================
	// data steering, registered so every output comes from a flop
	logic rc0_q, rc1_q, pc0_q, pc1_q;
	logic [1:0] route;
	assign route = cfg_q[ccp_pkg::CFG_OUT_MSB:ccp_pkg::CFG_OUT_LSB];
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			rc0_q <= 1'b0;
			rc1_q <= 1'b0;
			pc0_q <= 1'b0;
			pc1_q <= 1'b0;
		end else begin
			rc0_q <= cfg_q[ccp_pkg::CFG_SWAP_BIT] ? rec_c1_in : rec_c0_in;
			rc1_q <= cfg_q[ccp_pkg::CFG_SWAP_BIT] ? rec_c0_in : rec_c1_in;
			// default routing sends to codec 1, the one always fitted
			pc0_q <= play_in && (route == ccp_pkg::ROUTE_C0
				|| route == ccp_pkg::ROUTE_BOTH);
			pc1_q <= play_in && (route != ccp_pkg::ROUTE_C0);
		end
	end

	// ==========================================================
	// outputs
	assign cmd_ready_out        = rdy_q;
	assign resp_ready_out       = resp_rdy_q;
	assign resp_word_out        = resp_q;
	assign cmd_error_out        = err_q;
	assign linear16_out         = cfg_q[ccp_pkg::CFG_WIDTH_BIT];
	assign alaw_out             = cfg_q[ccp_pkg::CFG_LAW_BIT];
	assign master_out           = master;
	assign long_sync_out        = cfg_q[ccp_pkg::CFG_LONG_BIT];
	assign play_route_out       = route;
	assign in_swap_out          = cfg_q[ccp_pkg::CFG_SWAP_BIT];
	assign recording_format_out = rec_q[ccp_pkg::REC_FMT_MSB:ccp_pkg::REC_FMT_LSB];
	assign tfr_port_out         = tfr_port_q;
	assign tfr_reserved_out     = tfr_rsv_q;
	assign rec_c0_out           = rc0_q;
	assign rec_c1_out           = rc1_q;
	assign play_c0_out          = pc0_q;
	assign play_c1_out          = pc1_q;
	assign bit_clock_out        = bclk_q;
	assign bit_clock_oe_out     = master;
	assign frame_sync_out       = fs_q;
	assign frame_sync_oe_out    = master;
	assign frame_start_out      = fstart_q;

	// ==========================================================
	// checks
	AST_ECHO: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		cmd_wr_in && rdy_q |=> resp_ready_out && resp_word_out == $past(cmd_word_in))
		else $error("response does not echo command");
	AST_DIVFOLLOW: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		resp_ready_out && resp_rd_in && div_next_q
		|=> state_q == ccp_pkg::CCP_DIV && cmd_ready_out)
		else $error("divider word not expected after set-rate");
	AST_RDCLR: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		resp_ready_out && resp_rd_in |=> !resp_ready_out && cmd_ready_out)
		else $error("read did not clear response ready");
	AST_SLAVE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		!master |-> !bit_clock_oe_out && !frame_sync_oe_out)
		else $error("slave drives codec clocks");
	AST_WIDTH: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		width_set_q |=> $stable(linear16_out))
		else $error("width changed after set");
	AST_ROUTE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		route == ccp_pkg::ROUTE_BOTH && play_in && $stable(route)
		|=> play_c0_out && play_c1_out)
		else $error("both-codec routing failed");
	AST_SWAP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		cfg_q[ccp_pkg::CFG_SWAP_BIT] && $stable(cfg_q) |=> rec_c0_out == $past(rec_c1_in))
		else $error("input swap not applied");
	AST_SYNC1: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		frame_tick && master && !div_q[ccp_pkg::DIV_WIDE_BIT]
		|=> sync_cnt_q == ccp_pkg::SYNC_LEN_1)
		else $error("narrow sync length wrong");
	AST_LAW: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		cmd_wr_in && state_q == ccp_pkg::CCP_IDLE && cfg_hit
		|=> alaw_out == $past(cmd_word_in[ccp_pkg::CFG_LAW_BIT]))
		else $error("law output mismatch");
endmodule : ccp_codec_port
`default_nettype wire

// ===== ccp_codec_model.sv
`default_nettype none
// pair of codecs of one type sharing one frame; drives the clocks in slave mode
module ccp_codec_model #(
	parameter int FRAME = 32
) (
	// clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rst_b_in,
	// device drives the clocks
	input  wire logic release_in,
	// codec outputs
	output logic      rec_c0_out,
	output logic      rec_c1_out,
	output logic      bit_clock_out,
	output logic      frame_sync_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int          cnt = 0;
	logic [15:0] pat = 16'h_1D2B;
	initial begin
		rec_c0_out = 1'b0;
		rec_c1_out = 1'b0;
		bit_clock_out = 1'b0;
		frame_sync_out = 1'b0;
	end
	// ==========================================================
	// both codecs frame on the same sync, so they are one type
	always @(posedge clk_sys_in) begin
		cnt <= rst_b_in ? (cnt + 1) % FRAME : 0;
		pat <= {pat[14:0], pat[15] ^ pat[13] ^ pat[12] ^ pat[10]};
		rec_c0_out <= pat[0];
		rec_c1_out <= pat[7];
		if (release_in) begin
			// released lines have no pull, so they toggle rather than hold
			bit_clock_out <= ~bit_clock_out;
			frame_sync_out <= ~frame_sync_out;
		end else begin
			bit_clock_out <= cnt[0];
			frame_sync_out <= (cnt == 0);
		end
	end
endmodule : ccp_codec_model
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, cmd_wr_in = 1'b0, resp_rd_in = 1'b0;
	logic        play_in = 1'b0;
	logic [15:0] cmd_word_in = 16'h_0000;
	logic [15:0] rnd = 16'h_E31A;
	logic [15:0] resp_word_out;
	logic [2:0]  recording_format_out;
	logic [1:0]  play_route_out;
	logic        cmd_ready_out, resp_ready_out, cmd_error_out, linear16_out, alaw_out;
	logic        master_out, long_sync_out, in_swap_out, tfr_port_out, tfr_reserved_out;
	logic        rec_c0_in, rec_c1_in, rec_c0_out, rec_c1_out, play_c0_out, play_c1_out;
	logic        bit_clock_out, bit_clock_oe_out, frame_sync_out, frame_sync_oe_out;
	logic        frame_start_out, m_bc, m_fs, bc_line, fs_line, fs_prev = 1'b0;
	int          fail_count = 0, num_checks = 0, cyc = 0, fst_cnt = 0;
	int          fs_rise = 0, fs_per = 0, fs_hi = 0, bc_last = 0, bc_per = 0;
	// ==========================================================
	// clock, wire resolution, dut and codec pair
	always #4 clk_sys_in = ~clk_sys_in;
	assign bc_line = bit_clock_oe_out ? bit_clock_out : m_bc;
	assign fs_line = frame_sync_oe_out ? frame_sync_out : m_fs;
	ccp_codec_port u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.cmd_wr_in(cmd_wr_in), .cmd_word_in(cmd_word_in), .resp_rd_in(resp_rd_in),
		.cmd_ready_out(cmd_ready_out), .resp_ready_out(resp_ready_out),
		.resp_word_out(resp_word_out), .cmd_error_out(cmd_error_out),
		.linear16_out(linear16_out), .alaw_out(alaw_out), .master_out(master_out),
		.long_sync_out(long_sync_out), .play_route_out(play_route_out),
		.in_swap_out(in_swap_out), .recording_format_out(recording_format_out),
		.tfr_port_out(tfr_port_out), .tfr_reserved_out(tfr_reserved_out),
		.rec_c0_in(rec_c0_in), .rec_c1_in(rec_c1_in), .play_in(play_in),
		.rec_c0_out(rec_c0_out), .rec_c1_out(rec_c1_out), .play_c0_out(play_c0_out),
		.play_c1_out(play_c1_out), .bit_clock_in(bc_line), .frame_sync_in(fs_line),
		.bit_clock_out(bit_clock_out), .bit_clock_oe_out(bit_clock_oe_out),
		.frame_sync_out(frame_sync_out), .frame_sync_oe_out(frame_sync_oe_out),
		.frame_start_out(frame_start_out));
	ccp_codec_model #(.FRAME(32)) u_codec (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.release_in(bit_clock_oe_out), .rec_c0_out(rec_c0_in), .rec_c1_out(rec_c1_in),
		.bit_clock_out(m_bc), .frame_sync_out(m_fs));
	// ==========================================================
	// edge monitor: periods and widths in main clock cycles
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (frame_start_out === 1'b1) fst_cnt <= fst_cnt + 1;
		if (bit_clock_out === 1'b1) begin
			bc_per <= cyc - bc_last;
			bc_last <= cyc;
		end
		if (frame_sync_out === 1'b1 && !fs_prev) begin
			fs_per <= cyc - fs_rise;
			fs_rise <= cyc;
		end
		if (frame_sync_out === 1'b0 && fs_prev) fs_hi <= cyc - fs_rise;
		fs_prev <= (frame_sync_out === 1'b1);
		if (cyc == 20000) begin
			fail_count++;
			$display("CHECK FAILED t=%0t timeout", $time);
			complete_run();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic [15:0] cfg(input logic w, l, m, lg, input logic [1:0] r,
			input logic s, rt);
		return {4'h_C, 3'h_2, w, l, m, lg, r, s, rt, 1'b0};
	endfunction : cfg
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	// reset held 20 cycles; idle outputs afterwards
	task automatic do_reset();
		rst_b_in <= 1'b0;
		repeat (20) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		@(posedge clk_sys_in);
		#1;
		chk(cmd_ready_out, 1'b1);
		chk(resp_ready_out, 1'b0);
		chk({master_out, bit_clock_oe_out, frame_sync_oe_out}, 3'h_0);
	endtask : do_reset
	// one command, echo compared, response read back
	task automatic send(input logic [15:0] w);
		int n;
		logic [7:0] lo, hi;
		lo = w[7:0];
		hi = w[15:8];
		@(posedge clk_sys_in);
		cmd_wr_in <= 1'b1;
		cmd_word_in <= {hi, lo}; // host pairs high byte then low byte
		@(posedge clk_sys_in);
		cmd_wr_in <= 1'b0;
		#1;
		for (n = 0; resp_ready_out !== 1'b1 && n < 20; n++) begin
			@(posedge clk_sys_in);
			#1;
		end
		chk(resp_word_out, w);
		chk(cmd_ready_out, 1'b0);
		@(posedge clk_sys_in);
		resp_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		resp_rd_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		chk({resp_ready_out, cmd_ready_out}, 2'h_1);
	endtask : send
	task automatic check_cfg(input logic w, l, m, lg, input logic [1:0] r, input logic s);
		chk(linear16_out, w);
		chk(alaw_out, l);
		chk({master_out, bit_clock_oe_out, frame_sync_oe_out}, {3{m}});
		chk(long_sync_out, lg);
		chk(play_route_out, r);
		chk(in_swap_out, s);
	endtask : check_cfg
	// playback bit steered by route, record bits by swap, one cycle late
	task automatic steer(input logic [1:0] r, input logic s);
		logic b, r0, r1;
		@(posedge clk_sys_in);
		b = rnd[0];
		rnd = lfsr(rnd);
		play_in <= b;
		#1;
		r0 = rec_c0_in;
		r1 = rec_c1_in;
		@(posedge clk_sys_in);
		#1;
		chk({play_c0_out, play_c1_out}, {b & r[1], b & (r != 2'h_2)});
		chk({rec_c0_out, rec_c1_out}, s ? {r1, r0} : {r0, r1});
	endtask : steer
	// ==========================================================
	// main sequence
	initial begin
		logic l, lg, wd;
		int   c0, bd, fd;
		do_reset();
		for (int i = 0; i < 8; i++) begin
			l = rnd[3];
			lg = rnd[5];
			rnd = lfsr(rnd);
			// slave setup with set-rate bit clear, so no divider word follows
			// i = 0 is route 00 with no swap, the speakerphone setup
			send(cfg(1'b0, l, 1'b0, lg, 2'(i), i[2], 1'b0));
			check_cfg(1'b0, l, 1'b0, lg, 2'(i), i[2]);
			repeat (3) steer(2'(i), i[2]);
		end
		c0 = fst_cnt;
		repeat (128) @(posedge clk_sys_in);
		#1;
		chk(16'(fst_cnt - c0), 16'h_0004);
		send(cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'h_0, 1'b0, 1'b0));
		chk({cmd_error_out, linear16_out}, 2'h_2);
		$display("test slave config done");
		for (int t = 0; t < 4; t++) begin
			rnd = lfsr(rnd);
			send({4'h_1, 2'h_3, rnd[2:0], 5'h_00, 2'(t)});
			chk(recording_format_out, rnd[2:0]);
			chk({tfr_port_out, tfr_reserved_out}, {t == 3, t == 1 || t == 2});
		end
		$display("test record word done");
		for (int k = 0; k < 3; k++) begin
			do_reset();
			wd = (k == 2);
			lg = (k != 0);
			bd = 5 + k;
			fd = 33; // keeps bit clock over 32x frame rate
			send(cfg(wd, 1'b1, 1'b1, lg, 2'h_3, 1'b0, 1'b1));
			send({lg, 10'(fd), 5'(bd)});
			check_cfg(wd, 1'b1, 1'b1, lg, 2'h_3, 1'b0);
			repeat (3 * (fd + 1) * (bd + 1)) @(posedge clk_sys_in);
			#1;
			chk(16'(bc_per), 16'(bd + 1));
			chk(16'(fs_per), 16'((fd + 1) * (bd + 1)));
			chk(16'(fs_hi), 16'((lg ? (wd ? 16 : 8) : 1) * (bd + 1)));
		end
		$display("test master clocks done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
